// ==== logic/dcw_top.sv ====
// drive command word decoder with APB register access
//
// Overview of operation
// - command word has no effect unless the enable setting is one, except that bit 12 high always blocks a command word trip clear.
// - bits 0-9 sequencing and reference, 12 trip, 13 reset, 14 watchdog.
// - regen mode ignores word bits 1 to 6, 8 and 9.
// - enable plus auto bit hands bits 0-6 and 9 the sequencing.
// - sequencing parameters keep their values but stop steering while the word rules, save all bits but drive_enable in regen mode.
// - enable or auto bit low returns sequencing to the parameters.
// - enabled word copies bit 8 into the reference select parameter.
// - reference select zero picks analogue ref 1, one picks preset 1.
// - enabled word with bit 12 high raises the command word trip.
// - trip stays set while bit 12 is high; controller drops it first.
// - enabled word resets the drive on each rising edge of bit 13.
// - a word-driven reset leaves the reset parameter untouched.
// - rising bit 14 starts the watchdog or services it when running, except while a comms stall holds it.
// - watchdog unserviced for one second raises the link watchdog trip.
// - trip disables the watchdog; a fresh edge re-enables it after reset.
// - after a comms stall the watchdog gets two more seconds of grace.
// - supply indicator latches at undervoltage trip reset: 0 mains, 1 battery.
// - mains mode saves power-down parameters when the undervoltage trip occurs.
// - battery mode skips the power-down parameter save.
// - battery mode on small frames takes voltages from the auxiliary supply.
`timescale 1ns/1ps
`include "dcw_consts.svh"
module dcw_top #(
  parameter int unsigned WDOG_CYC  = `DCW_WDOG_MS * 1000 * `DCW_CLK_MHZ,
  parameter int unsigned GRACE_CYC = `DCW_GRACE_MS * 1000 * `DCW_CLK_MHZ
) (
  // clock and reset
  input  wire logic                   clk,
  input  wire logic                   rst_n,
  // apb slave
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [`DCW_ADDR_W-1:0] paddr,
  input  wire logic [31:0]            pwdata,
  output logic      [31:0]            prdata,
  output logic                        pready,
  output logic                        pslverr,
  // power and link status
  input  wire logic                   uv_trip,
  input  wire logic                   battery_sense,
  input  wire logic                   small_frame,
  input  wire logic                   comms_stalled,
  // drive functions
  output dcw_pkg::dcw_seq_t           seq_out,
  output logic                        ref_preset,
  output logic                        drive_reset,
  output logic                        cw_trip,
  output logic                        wd_trip,
  output logic                        save_pd,
  output logic                        volt_from_aux
);
  import dcw_pkg::*;

  logic [15:0] drive_command_word;
  logic        command_word_enable;
  logic        regen_mode;
  dcw_seq_t    drive_enable_parameter;
  logic        reference_select_parameter;
  logic        reset_parameter;
  logic        supply_mode_indicator;
  logic        uv_prev;

  logic        apb_done;
  logic        wr_en;
  logic        cw_in_ctrl;
  logic [1:0]  rise;
  logic        clr_cw;
  logic        clr_wd;
  logic        wd_running;
  logic        wd_trip_int;
  logic        next_cw_trip;
  dcw_seq_t    next_seq;
  logic [31:0] next_rdata;
  logic        next_err;

  if (WDOG_CYC < 2 || GRACE_CYC < 2) begin : g_chk
    $error("watchdog counts must be at least two cycles");
  end

  // one wait state: pready comes from a flop set in the first access cycle
  assign apb_done = psel & penable & pready;
  assign wr_en    = apb_done & pwrite;

  // auto/manual gates only sequencing, not trip, reset or watchdog
  assign cw_in_ctrl = command_word_enable & drive_command_word[`DCW_B_AUTO];

  dcw_rise #(
    .WIDTH (2)
  ) u_rise (
    .clk    (clk),
    .rst_n  (rst_n),
    .enable (command_word_enable),
    .level  (drive_command_word[`DCW_B_WDOG:`DCW_B_RESET]),
    .rise   (rise)
  );

  assign clr_wd = (wr_en && paddr == `DCW_OFF_TRIPCLR && pwdata[`DCW_CLR_WDTRIP]) || rise[0];
  assign clr_cw = (wr_en && paddr == `DCW_OFF_TRIPCLR && pwdata[`DCW_CLR_CWTRIP]) || rise[0];

  dcw_watchdog #(
    .TIMEOUT_CYC (WDOG_CYC),
    .GRACE_CYC   (GRACE_CYC)
  ) u_wdog (
    .clk           (clk),
    .rst_n         (rst_n),
    .service       (rise[1]),
    .clear_trip    (clr_wd),
    .comms_stalled (comms_stalled),
    .running       (wd_running),
    .trip          (wd_trip_int)
  );

  // bits 10, 11 and 15 are stored and read back but drive nothing
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      drive_command_word <= `DCW_WORD_RST;
    end else if (wr_en && paddr == `DCW_OFF_WORD) begin
      drive_command_word <= pwdata[15:0];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      command_word_enable <= 1'b0;
      regen_mode          <= 1'b0;
    end else if (wr_en && paddr == `DCW_OFF_CTRL) begin
      command_word_enable <= pwdata[`DCW_CTRL_ENABLE];
      regen_mode          <= pwdata[`DCW_CTRL_REGEN];
    end
  end

  // the word never writes these; they only lose control while it rules
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      drive_enable_parameter <= `DCW_PARAM_RST;
      reset_parameter        <= 1'b0;
    end else if (wr_en && paddr == `DCW_OFF_PARAM) begin
      drive_enable_parameter <= pwdata[7:0];
      reset_parameter        <= pwdata[`DCW_PARAM_RESET];
    end
  end

  // hardware copy overrides a software write in the same cycle
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      reference_select_parameter <= 1'b0;
    end else if (command_word_enable && !regen_mode) begin
      reference_select_parameter <= drive_command_word[`DCW_B_REFSEL];
    end else if (wr_en && paddr == `DCW_OFF_PARAM) begin
      reference_select_parameter <= pwdata[`DCW_PARAM_REFSEL];
    end
  end

  always_comb begin
    next_seq = drive_enable_parameter;
    if (cw_in_ctrl) begin
      next_seq = dcw_word_seq(drive_command_word, regen_mode, drive_enable_parameter);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      seq_out    <= '0;
      ref_preset <= 1'b0;
    end else begin
      seq_out    <= next_seq;
      ref_preset <= reference_select_parameter;
    end
  end

  // clear refused while bit 12 still high, so the set always wins
  always_comb begin
    next_cw_trip = cw_trip;
    if (clr_cw && !drive_command_word[`DCW_B_TRIP]) begin
      next_cw_trip = 1'b0;
    end
    if (command_word_enable && drive_command_word[`DCW_B_TRIP]) begin
      next_cw_trip = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cw_trip     <= 1'b0;
      wd_trip     <= 1'b0;
      drive_reset <= 1'b0;
    end else begin
      cw_trip     <= next_cw_trip;
      wd_trip     <= wd_trip_int;
      drive_reset <= rise[0];
    end
  end

  // indicator is only trusted from the moment the undervoltage trip clears
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      uv_prev               <= 1'b0;
      supply_mode_indicator <= 1'b0;
      save_pd               <= 1'b0;
      volt_from_aux         <= 1'b0;
    end else begin
      uv_prev <= uv_trip;
      if (uv_prev && !uv_trip) begin
        supply_mode_indicator <= battery_sense;
      end
      save_pd       <= uv_trip && !uv_prev && !supply_mode_indicator;
      volt_from_aux <= supply_mode_indicator && small_frame;
    end
  end

  always_comb begin
    next_rdata = 32'h0;
    next_err   = 1'b0;
    case (paddr)
      `DCW_OFF_WORD:    next_rdata = {16'h0000, drive_command_word};
      `DCW_OFF_CTRL:    next_rdata = {30'h0, regen_mode, command_word_enable};
      `DCW_OFF_PARAM:   next_rdata = {22'h0, reset_parameter, reference_select_parameter,
                                      drive_enable_parameter};
      `DCW_OFF_STATUS:  next_rdata = {27'h0, cw_in_ctrl, supply_mode_indicator, wd_running,
                                      wd_trip_int, cw_trip};
      `DCW_OFF_TRIPCLR: next_rdata = 32'h0;
      default:          next_err   = 1'b1;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pready  <= 1'b0;
      prdata  <= 32'h0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & penable & ~pready;
      prdata  <= (psel & penable & ~pready & ~pwrite) ? next_rdata : 32'h0;
      pslverr <= psel & penable & ~pready & next_err;
    end
  end

  default clocking dcw_cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  word_off_a: assert property (
    !command_word_enable |=> seq_out == $past(drive_enable_parameter))
    else $error("word acted while disabled");
  seq_take_a: assert property (
    cw_in_ctrl && !regen_mode |=> seq_out.drive_enable == $past(drive_command_word[0])
      && seq_out.jog_rev == $past(drive_command_word[9]))
    else $error("sequencing not from word");
  regen_mask_a: assert property (
    cw_in_ctrl && regen_mode |=> seq_out.run_fwd == $past(drive_enable_parameter.run_fwd))
    else $error("regen did not mask word");
  ref_copy_a: assert property (
    command_word_enable && !regen_mode |=> ##1 ref_preset == $past(drive_command_word[8], 2))
    else $error("reference select not copied");
  trip_set_a: assert property (
    command_word_enable && drive_command_word[`DCW_B_TRIP] |=> cw_trip)
    else $error("word trip not raised");
  trip_hold_a: assert property (
    cw_trip && drive_command_word[`DCW_B_TRIP] |=> cw_trip)
    else $error("trip cleared with bit high");

  sequence reset_edge_s;
    command_word_enable && !drive_command_word[`DCW_B_RESET]
      ##1 command_word_enable && drive_command_word[`DCW_B_RESET];
  endsequence

  reset_pulse_a: assert property (
    reset_edge_s |=> drive_reset ##1 !drive_reset || rise[0])
    else $error("no reset on rising bit 13");
  reset_param_a: assert property (
    rise[0] && !(wr_en && paddr == `DCW_OFF_PARAM) |=> $stable(reset_parameter))
    else $error("reset parameter changed by word");
  supply_latch_a: assert property (
    uv_prev && !uv_trip |=> supply_mode_indicator == $past(battery_sense))
    else $error("supply indicator not latched");
  save_main_a: assert property (
    uv_trip && !uv_prev && !supply_mode_indicator |=> save_pd)
    else $error("no save in mains mode");
  save_batt_a: assert property (
    supply_mode_indicator && $stable(supply_mode_indicator) |=> !save_pd)
    else $error("save in battery mode");

  // every word-side effect but the bit 12 clear block must trace back to an enabled word
  trip_gate_a: assert property (
    $rose(cw_trip) |-> $past(command_word_enable && drive_command_word[`DCW_B_TRIP]))
    else $error("word trip raised while disabled");
  reset_gate_a: assert property (
    drive_reset |-> $past(command_word_enable && drive_command_word[`DCW_B_RESET]))
    else $error("reset pulse without enabled bit 13");
  seq_manual_a: assert property (
    command_word_enable && !drive_command_word[`DCW_B_AUTO]
      |=> seq_out == $past(drive_enable_parameter))
    else $error("manual bit did not hand back sequencing");
  ref_regen_a: assert property (
    regen_mode && !(wr_en && paddr == `DCW_OFF_PARAM) |=> $stable(reference_select_parameter))
    else $error("bit 8 copied in regen mode");

  // indicator must not wander between undervoltage trip resets
  supply_hold_a: assert property (
    !(uv_prev && !uv_trip) |=> $stable(supply_mode_indicator))
    else $error("supply indicator moved outside trip reset");
endmodule

// ==== logic/dcw_consts.svh ====
// register offsets, field positions, reset values and timing figures of the command word decoder
`ifndef DCW_CONSTS_SVH
`define DCW_CONSTS_SVH

`define DCW_ADDR_W        12
`define DCW_OFF_WORD      12'h000
`define DCW_OFF_CTRL      12'h004
`define DCW_OFF_PARAM     12'h008
`define DCW_OFF_STATUS    12'h00C
`define DCW_OFF_TRIPCLR   12'h010

`define DCW_B_ENABLE      0
`define DCW_B_AUTO        7
`define DCW_B_REFSEL      8
`define DCW_B_TRIP        12
`define DCW_B_RESET       13
`define DCW_B_WDOG        14

`define DCW_CTRL_ENABLE   0
`define DCW_CTRL_REGEN    1
`define DCW_PARAM_REFSEL  8
`define DCW_PARAM_RESET   9
`define DCW_CLR_CWTRIP    0
`define DCW_CLR_WDTRIP    1

`define DCW_WORD_RST      16'h0000
`define DCW_PARAM_RST     8'h00

`define DCW_CLK_MHZ       200
`define DCW_WDOG_MS       1000
`define DCW_GRACE_MS      2000

`endif

// ==== logic/dcw_pkg.sv ====
// types shared by the command word decoder
package dcw_pkg;

  typedef struct packed {
    logic jog_rev;
    logic not_stop;
    logic run;
    logic fwd_rev;
    logic run_rev;
    logic jog;
    logic run_fwd;
    logic drive_enable;
  } dcw_seq_t;

  typedef enum logic [1:0] {
    DCW_WD_OFF,
    DCW_WD_RUN,
    DCW_WD_HOLD,
    DCW_WD_GRACE
  } dcw_wd_state_t;

  // word bits 0..6 and 9 mapped onto the sequencing bundle
  function automatic dcw_seq_t dcw_word_seq(input logic [15:0] w,
                                            input logic regen,
                                            input dcw_seq_t fallback);
    dcw_seq_t s;
    s = regen ? fallback : {w[9], w[6:1], 1'b0};
    s.drive_enable = w[0];
    return s;
  endfunction

endpackage

// ==== logic/dcw_rise.sv ====
// rising edge detector on sampled command word bits
`timescale 1ns/1ps
module dcw_rise #(
  parameter int WIDTH = 2
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // sampled bits
  input  wire logic             enable,
  input  wire logic [WIDTH-1:0] level,
  output logic      [WIDTH-1:0] rise
);
  import dcw_pkg::*;

  logic [WIDTH-1:0] prev;

  if (WIDTH < 1) begin : g_chk
    $error("dcw_rise needs at least one bit");
  end

  // prev tracks even while disabled, so a bit already high at enable gives no edge
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      prev <= '0;
    end else begin
      prev <= level;
    end
  end

  assign rise = enable ? (level & ~prev) : '0;

  rise_needs_low_a: assert property (@(posedge clk) disable iff (!rst_n)
    |rise |-> enable && |(~$past(level) & level)) else $error("edge without low to high");
endmodule

// ==== logic/dcw_watchdog.sv ====
// link watchdog with stall hold and recovery grace period
`timescale 1ns/1ps
module dcw_watchdog #(
  parameter int unsigned TIMEOUT_CYC = 200000000,
  parameter int unsigned GRACE_CYC   = 400000000
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // control
  input  wire logic service,
  input  wire logic clear_trip,
  input  wire logic comms_stalled,
  // state
  output logic      running,
  output logic      trip
);
  import dcw_pkg::*;

  dcw_wd_state_t state;
  logic [31:0]   cnt;
  logic          timeout_hit;

  if (TIMEOUT_CYC < 2 || GRACE_CYC < 2) begin : g_chk
    $error("watchdog counts must be at least two cycles");
  end

  assign timeout_hit = (state == DCW_WD_RUN) && !service && !comms_stalled && (cnt == 32'h1);
  assign running     = (state != DCW_WD_OFF);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state <= DCW_WD_OFF;
      cnt   <= 32'h0;
    end else begin
      case (state)
        DCW_WD_OFF: begin
          // a tripped watchdog waits for the trip reset before a new edge counts
          if (service && !trip) begin
            state <= DCW_WD_RUN;
            cnt   <= TIMEOUT_CYC;
          end
        end
        DCW_WD_RUN: begin
          if (service) begin
            cnt <= TIMEOUT_CYC;
          end else if (comms_stalled) begin
            state <= DCW_WD_HOLD;
          end else if (cnt == 32'h1) begin
            state <= DCW_WD_OFF;
          end else begin
            cnt <= cnt - 32'h1;
          end
        end
        DCW_WD_HOLD: begin
          if (!comms_stalled) begin
            state <= DCW_WD_GRACE;
            cnt   <= GRACE_CYC;
          end
        end
        DCW_WD_GRACE: begin
          if (service || cnt == 32'h1) begin
            state <= DCW_WD_RUN;
            cnt   <= TIMEOUT_CYC;
          end else if (comms_stalled) begin
            state <= DCW_WD_HOLD;
          end else begin
            cnt <= cnt - 32'h1;
          end
        end
        default: state <= DCW_WD_OFF;
      endcase
    end
  end

  // set wins over a clear in the same cycle
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      trip <= 1'b0;
    end else begin
      trip <= timeout_hit | (trip & ~clear_trip);
    end
  end

  sequence wd_last_tick_s;
    state == DCW_WD_RUN && cnt == 32'h1 && !service && !comms_stalled;
  endsequence

  wd_timeout_trip_a: assert property (@(posedge clk) disable iff (!rst_n)
    wd_last_tick_s |=> trip && !running) else $error("no trip at timeout");
  wd_trip_off_a: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(trip) |-> state == DCW_WD_OFF) else $error("watchdog still on after trip");
  wd_grace_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    state == DCW_WD_GRACE |-> !trip || $past(trip)) else $error("trip during grace");
endmodule

// ==== sim/dcw_ctrl_model.sv ====
// apb master standing in for the external controller
`timescale 1ns/1ps
`include "dcw_consts.svh"
module dcw_ctrl_model (
  // clock
  input  wire logic                   clk,
  // apb master side
  output logic                        psel,
  output logic                        penable,
  output logic                        pwrite,
  output logic [`DCW_ADDR_W-1:0]      paddr,
  output logic [31:0]                 pwdata,
  input  wire logic [31:0]            prdata,
  input  wire logic                   pready,
  input  wire logic                   pslverr
);
  initial begin
    psel    <= 1'b0;
    penable <= 1'b0;
    pwrite  <= 1'b0;
    paddr   <= '0;
    pwdata  <= '0;
  end

  // one transfer; no fixed latency assumed, the bench timeout ends a hang
  task automatic xfer(input logic wr, input logic [`DCW_ADDR_W-1:0] a,
                      input logic [31:0] d, output logic [31:0] q, output logic err);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule

// ==== sim/dcw_top_test.sv ====
// self-checking bench for the command word decoder
`timescale 1ns/1ps
`include "dcw_consts.svh"
module dcw_top_test;
  import dcw_pkg::*;
  // short counts keep the run brief
  localparam int unsigned WD = 50;
  localparam int unsigned GR = 80;
  logic                   clk;
  logic                   rst_n;
  logic                   psel;
  logic                   penable;
  logic                   pwrite;
  logic [`DCW_ADDR_W-1:0] paddr;
  logic [31:0]            pwdata;
  logic [31:0]            prdata;
  logic                   pready;
  logic                   pslverr;
  logic                   uv_trip;
  logic                   battery_sense;
  logic                   small_frame;
  logic                   comms_stalled;
  dcw_seq_t               seq_out;
  logic                   ref_preset;
  logic                   drive_reset;
  logic                   cw_trip;
  logic                   wd_trip;
  logic                   save_pd;
  logic                   volt_from_aux;
  logic [31:0]            q;
  logic                   e;
  int                     error_cnt = 0;
  int                     checks = 0;
  int                     rst_cnt = 0;
  int                     pd_cnt = 0;
  int                     cyc = 0;

  dcw_top #(.WDOG_CYC(WD), .GRACE_CYC(GR)) uut (
    .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .uv_trip(uv_trip), .battery_sense(battery_sense),
    .small_frame(small_frame), .comms_stalled(comms_stalled), .seq_out(seq_out),
    .ref_preset(ref_preset), .drive_reset(drive_reset), .cw_trip(cw_trip),
    .wd_trip(wd_trip), .save_pd(save_pd), .volt_from_aux(volt_from_aux));

  dcw_ctrl_model ctl (
    .clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic test_done();
    $display("checks %0d, error_cnt %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cyc++;
    if (drive_reset === 1'b1)
      rst_cnt++;
    if (save_pd === 1'b1)
      pd_cnt++;
    if (cyc == 20000) begin
      error_cnt++;
      test_done();
    end
  end

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, got);
    end
  endtask

  task automatic wr(input logic [`DCW_ADDR_W-1:0] a, input logic [31:0] d);
    ctl.xfer(1'b1, a, d, q, e);
  endtask

  task automatic rd(input logic [`DCW_ADDR_W-1:0] a, input logic [31:0] x, input string nm);
    ctl.xfer(1'b0, a, 32'h0, q, e);
    chk(nm, x, q);
  endtask

  // outputs are looked at one step after the edge so its updates have landed
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  initial begin
    rst_n = 1'b0;
    uv_trip = 1'b0;
    battery_sense = 1'b0;
    small_frame = 1'b1;
    comms_stalled = 1'b0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    rd(`DCW_OFF_STATUS, 32'h0, "status");
    rd(`DCW_OFF_TRIPCLR, 32'h0, "tripclr");
    rd(12'h020, 32'h0, "unmapped");
    chk("slverr", 32'h1, 32'(e));
    wr(`DCW_OFF_PARAM, 32'h0255);
    wr(`DCW_OFF_WORD, 32'h7181);
    tick(3);
    chk("seq_out", 32'h55, 32'(seq_out));
    chk("ref_preset", 32'h0, 32'(ref_preset));
    rd(`DCW_OFF_STATUS, 32'h0, "status");
    chk("cw_trip", 32'h0, 32'(cw_trip));
    chk("resets", 32'h0, 32'(rst_cnt));
    wr(`DCW_OFF_WORD, 32'h0);
    wr(`DCW_OFF_CTRL, 32'h1);
    wr(`DCW_OFF_WORD, 32'h8E83);
    tick(3);
    chk("seq_out", 32'h83, 32'(seq_out));
    rd(`DCW_OFF_PARAM, 32'h0255, "param");
    wr(`DCW_OFF_WORD, 32'h0003);
    tick(3);
    chk("seq_out", 32'h55, 32'(seq_out));
    wr(`DCW_OFF_WORD, 32'h0100);
    tick(3);
    chk("ref_preset", 32'h1, 32'(ref_preset));
    // the enabled word copies bit 8 into reference select, so the read-back shows it set
    rd(`DCW_OFF_PARAM, 32'h0355, "param");
    wr(`DCW_OFF_WORD, 32'h0);
    tick(3);
    chk("ref_preset", 32'h0, 32'(ref_preset));
    wr(`DCW_OFF_CTRL, 32'h3);
    wr(`DCW_OFF_WORD, 32'h03FE);
    tick(3);
    chk("seq_out", 32'h54, 32'(seq_out));
    chk("ref_preset", 32'h0, 32'(ref_preset));
    wr(`DCW_OFF_CTRL, 32'h1);
    wr(`DCW_OFF_WORD, 32'h1000);
    tick(3);
    chk("cw_trip", 32'h1, 32'(cw_trip));
    wr(`DCW_OFF_TRIPCLR, 32'h1);
    tick(3);
    chk("cw_trip", 32'h1, 32'(cw_trip));
    wr(`DCW_OFF_WORD, 32'h0);
    tick(3);
    chk("cw_trip", 32'h1, 32'(cw_trip));
    wr(`DCW_OFF_TRIPCLR, 32'h1);
    tick(3);
    chk("cw_trip", 32'h0, 32'(cw_trip));
    wr(`DCW_OFF_WORD, 32'h2000);
    wr(`DCW_OFF_WORD, 32'h2000);
    tick(3);
    chk("resets", 32'h1, 32'(rst_cnt));
    wr(`DCW_OFF_WORD, 32'h0);
    wr(`DCW_OFF_WORD, 32'h2000);
    tick(3);
    chk("resets", 32'h2, 32'(rst_cnt));
    rd(`DCW_OFF_PARAM, 32'h0255, "param");
    wr(`DCW_OFF_CTRL, 32'h0);
    wr(`DCW_OFF_WORD, 32'h0);
    wr(`DCW_OFF_WORD, 32'h2000);
    wr(`DCW_OFF_CTRL, 32'h1);
    tick(3);
    chk("resets", 32'h2, 32'(rst_cnt));
    wr(`DCW_OFF_WORD, 32'h0);
    wr(`DCW_OFF_WORD, 32'h4000);
    rd(`DCW_OFF_STATUS, 32'h04, "status");
    repeat (6) begin
      wr(`DCW_OFF_WORD, 32'h0);
      wr(`DCW_OFF_WORD, 32'h4000);
      tick(20);
    end
    chk("wd_trip", 32'h0, 32'(wd_trip));
    tick(WD + 10);
    chk("wd_trip", 32'h1, 32'(wd_trip));
    wr(`DCW_OFF_WORD, 32'h0);
    wr(`DCW_OFF_WORD, 32'h4000);
    rd(`DCW_OFF_STATUS, 32'h02, "status");
    wr(`DCW_OFF_TRIPCLR, 32'h2);
    tick(3);
    chk("wd_trip", 32'h0, 32'(wd_trip));
    wr(`DCW_OFF_WORD, 32'h0);
    wr(`DCW_OFF_WORD, 32'h4000);
    rd(`DCW_OFF_STATUS, 32'h04, "status");
    @(posedge clk);
    comms_stalled <= 1'b1;
    tick(100);
    chk("wd_trip", 32'h0, 32'(wd_trip));
    @(posedge clk);
    comms_stalled <= 1'b0;
    tick(70);
    chk("wd_trip", 32'h0, 32'(wd_trip));
    tick(70);
    chk("wd_trip", 32'h1, 32'(wd_trip));
    wr(`DCW_OFF_TRIPCLR, 32'h2);
    @(posedge clk);
    uv_trip <= 1'b1;
    tick(3);
    chk("saves", 32'h1, 32'(pd_cnt));
    @(posedge clk);
    battery_sense <= 1'b1;
    tick(3);
    rd(`DCW_OFF_STATUS, 32'h00, "status");
    @(posedge clk);
    uv_trip <= 1'b0;
    tick(3);
    rd(`DCW_OFF_STATUS, 32'h08, "status");
    chk("volt_from_aux", 32'h1, 32'(volt_from_aux));
    @(posedge clk);
    uv_trip <= 1'b1;
    small_frame <= 1'b0;
    tick(3);
    chk("saves", 32'h1, 32'(pd_cnt));
    chk("volt_from_aux", 32'h0, 32'(volt_from_aux));
    @(posedge clk);
    battery_sense <= 1'b0;
    uv_trip <= 1'b0;
    tick(3);
    rd(`DCW_OFF_STATUS, 32'h00, "status");
    test_done();
  end
endmodule
